// ==== shared/fes_pkg.sv ====
// Overview of operation
// - during sector erase, write 0B0h with a sector select active means suspend
// - suspend honoured only in erase cycle; it also ends the erase time-out window
// - toggle flag stops 0.1 to 15 us after suspend, then flash reads normally
// - suspended: reads of erasing sector are invalid, other sectors valid
// - suspended: programming refused; only resume, reset-flash and reads accepted
// - reset-flash while suspended marks the erasing sector contents invalid
// - write 030h with a sector select active resumes a suspended erase
// - program or erase of a protected sector is ignored; verify reads stored data
// - protection bits readable by processor, never writable from the bus
// - primary protection status bit i is 1 when primary sector i protected
// - secondary status: bits 0-3 sector protection, bit 7 security lock, 4-6 zero
// - reset-flash is one write, optionally after AAh to 555h and 55h to AAAh
// - reset-flash after an error returns flash to read mode within 25 us
// - reset-flash during byte program or bulk erase is ignored
// - reset-flash during sector erase aborts it; read mode within 25 us
// - reset pulse aborts any flash cycle; recovery up to 25 us
// - sram answers only while its select is high
// - secondary sector select wins over primary sector select
// - sram and i/o selects win over any flash sector select
// - space map bits gate data reads and fetches per memory; bit 7 enables pio
// - toggle flag inverts on each status read while an operation runs
package fes_pkg;
  localparam int          CLK_MHZ         = 25;
  localparam int          SUSP_MIN_NS     = 100;   // toggle stops no sooner
  localparam int          SUSP_MAX_NS     = 15000; // toggle stops no later
  localparam int          RECOVER_US      = 25;
  localparam int          ERASE_TMO_US    = 100;
  localparam logic [11:0] SUSP_CYC        = 12'((SUSP_MIN_NS * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] RECOVER_CYC     = 12'(RECOVER_US * CLK_MHZ);
  localparam logic [11:0] ERASE_TMO_CYC   = 12'(ERASE_TMO_US * CLK_MHZ);
  // command codes
  localparam logic [7:0]  CMD_SUSPEND     = 8'hb0;
  localparam logic [7:0]  CMD_RESUME      = 8'h30;
  localparam logic [7:0]  CMD_RESET_FLASH = 8'hf0;
  localparam logic [7:0]  UNLOCK1_DATA    = 8'haa;
  localparam logic [7:0]  UNLOCK2_DATA    = 8'h55;
  localparam logic [11:0] UNLOCK1_ADDR    = 12'h555;
  localparam logic [11:0] UNLOCK2_ADDR    = 12'haaa;
  // register offsets inside the io register space
  localparam logic [7:0]  SPACE_MAP_OFS   = 8'hb2;
  localparam logic [7:0]  PROT_PRI_OFS    = 8'hc0;
  localparam logic [7:0]  PROT_SEC_OFS    = 8'hc2;
  // space map fields
  localparam int          MAP_PERIPHERAL_IO_ENABLE      = 7;
  localparam int          MAP_PRI_DATA    = 4;
  localparam int          MAP_SEC_DATA    = 3;
  localparam int          MAP_PRI_CODE    = 2;
  localparam int          MAP_SEC_CODE    = 1;
  localparam int          MAP_SRAM_CODE   = 0;
  localparam logic [7:0]  MAP_WR_MASK     = 8'h9f;
  // status byte fields
  localparam int          ST_TOGGLE       = 6;
  localparam int          ST_ERROR        = 5;
  localparam int          ST_TIMEOUT      = 3;
  localparam int          SEC_LOCK_BIT    = 7;

  typedef enum {
    S_READ, S_PROG, S_BULK, S_TMO, S_ERASE, S_SUSPENDING, S_SUSPENDED, S_RECOVER
  } fes_state_t;
endpackage

// ==== design/fes_flash_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module fes_flash_ctrl
  import fes_pkg::*;
#(
  parameter logic [7:0] SPACE_MAP_INIT = 8'h00
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  // processor bus, same clock
  input  wire logic [15:0] busAddr,
  input  wire logic [7:0]  busWrData,
  input  wire logic        busWr,
  input  wire logic        busRd,
  input  wire logic        programFetchStrobe,
  // decode logic array selects
  input  wire logic [7:0]  primarySectorSelects,
  input  wire logic [3:0]  secondarySectorSelects,
  input  wire logic        sramSelect,
  input  wire logic        ioRegisterSpace,
  input  wire logic        peripheralIoSelect,
  // instruction decoder and embedded algorithm
  input  wire logic        cmdProgram,
  input  wire logic        cmdSectorErase,
  input  wire logic        cmdBulkErase,
  input  wire logic        algoDone,
  input  wire logic        algoError,
  // protection, set only through the test port
  input  wire logic [7:0]  primaryProtect,
  input  wire logic [3:0]  secondaryProtect,
  input  wire logic        securityLock,
  // outputs
  output logic             startProgram,
  output logic             startSectorErase,
  output logic             startBulkErase,
  output logic [11:0]      eraseSectors,
  output logic             eraseHold,
  output logic             eraseAbort,
  output logic [11:0]      sectorInvalid,
  output logic             flashBusy,
  output logic [7:0]       readData,
  output logic             readDataValid,
  output logic             readDataInvalid,
  output logic [7:0]       primaryGrant,
  output logic [3:0]       secondaryGrant,
  output logic             sramGrant,
  output logic             ioGrant,
  output logic             peripheralGrant,
  output logic             toggleFlag,
  output logic             errorFlag,
  output logic             eraseTimeoutFlag
);

  typedef struct packed {
    fes_state_t  state;
    logic [11:0] cnt;
    logic        toggle;
    logic        err;
    logic [1:0]  unlock;
    logic [11:0] eraseSec;
    logic [11:0] invalid;
    logic [7:0]  spaceMap;
    logic        startProg;
    logic        startErase;
    logic        startBulk;
    logic        abort;
    logic [7:0]  rdData;
    logic        rdValid;
    logic        rdInvalid;
    logic [7:0]  priGrant;
    logic [3:0]  secGrant;
    logic        sramGnt;
    logic        ioGnt;
    logic        pioGnt;
    logic        hold;
    logic        busy;
    logic        tmoFlag;
  } fes_regs_t;

  fes_regs_t q_r;
  fes_regs_t q_nxt;
  logic [1:0] rstSync_r;
  logic       rstN;

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rstSync_r <= 2'b00;
    end else begin
      rstSync_r <= {rstSync_r[0], 1'b1};
    end
  end
  assign rstN = rstSync_r[1];

  // sector selects as one vector: bits 0-7 primary, 8-11 secondary
  function automatic logic [11:0] secVec(input logic [7:0] pri, input logic [3:0] sec);
    secVec = {sec, pri};
  endfunction

  // flash target after priority: secondary hides primary
  function automatic logic [11:0] flashTarget(input logic [7:0] pri, input logic [3:0] sec);
    flashTarget = (|sec) ? {sec, 8'h00} : {4'h0, pri};
  endfunction

  logic [11:0] selAll;
  logic [11:0] target;
  logic [11:0] protAll;
  logic        anySel;
  logic        cmdWr;
  logic        isSuspend;
  logic        isResume;
  logic        isReset;
  logic        isUnlock;
  logic        hiPri;
  logic        flashRd;
  logic        busyState;

  // command and target decode, shared by the state machine and read path
  always_comb begin
    selAll    = secVec(primarySectorSelects, secondarySectorSelects);
    target    = flashTarget(primarySectorSelects, secondarySectorSelects);
    protAll   = secVec(primaryProtect, secondaryProtect);
    anySel    = |selAll;
    hiPri     = sramSelect | ioRegisterSpace | peripheralIoSelect;
    cmdWr     = busWr & anySel & ~hiPri;
    isSuspend = cmdWr & (busWrData == CMD_SUSPEND);
    isResume  = cmdWr & (busWrData == CMD_RESUME);
    // a reset-flash may stand alone or follow the full unlock pair
    isReset   = cmdWr & (busWrData == CMD_RESET_FLASH)
              & (q_r.unlock != 2'd1);
    isUnlock  = cmdWr & ((busWrData == UNLOCK1_DATA && busAddr[11:0] == UNLOCK1_ADDR)
              | (busWrData == UNLOCK2_DATA && busAddr[11:0] == UNLOCK2_ADDR));
    flashRd   = (busRd | programFetchStrobe) & anySel & ~hiPri;
    busyState = (q_r.state == S_PROG) | (q_r.state == S_BULK) | (q_r.state == S_TMO)
              | (q_r.state == S_ERASE) | (q_r.state == S_SUSPENDING);
  end

  // next-state logic for the whole block
  always_comb begin
    q_nxt            = q_r;
    q_nxt.startProg  = 1'b0;
    q_nxt.startErase = 1'b0;
    q_nxt.startBulk  = 1'b0;
    q_nxt.abort      = 1'b0;
    q_nxt.rdValid    = 1'b0;
    q_nxt.rdInvalid  = 1'b0;
    q_nxt.rdData     = 8'h00;

    // unlock pair tracking; any other command write restarts it
    if (cmdWr) begin
      if (busWrData == UNLOCK1_DATA && busAddr[11:0] == UNLOCK1_ADDR) begin
        q_nxt.unlock = 2'd1;
      end else if (q_r.unlock == 2'd1 && busWrData == UNLOCK2_DATA
                   && busAddr[11:0] == UNLOCK2_ADDR) begin
        q_nxt.unlock = 2'd2;
      end else begin
        q_nxt.unlock = 2'd0;
      end
    end

    case (q_r.state)
      S_READ: begin
        if (isReset) begin
          q_nxt.err = 1'b0;
        end else if (cmdProgram) begin
          if ((target & protAll) == 12'h000) begin
            q_nxt.startProg = 1'b1;
            q_nxt.state     = S_PROG;
          end
        end else if (cmdSectorErase) begin
          if ((target & protAll) == 12'h000) begin
            q_nxt.eraseSec = target;
            q_nxt.cnt      = 12'h000;
            q_nxt.state    = S_TMO;
          end
        end else if (cmdBulkErase) begin
          // protected sectors drop out of the bulk set silently
          q_nxt.eraseSec  = ~protAll;
          q_nxt.startBulk = 1'b1;
          q_nxt.state     = S_BULK;
        end
      end
      S_PROG, S_BULK: begin
        // reset-flash writes fall through unseen here
        if (algoError) begin
          q_nxt.err      = 1'b1;
          q_nxt.eraseSec = 12'h000;
          q_nxt.state    = S_READ;
        end else if (algoDone) begin
          q_nxt.eraseSec = 12'h000;
          q_nxt.state    = S_READ;
        end
      end
      S_TMO: begin
        if (isSuspend) begin
          // suspend here also ends the time-out window, so the engine starts held
          q_nxt.startErase = 1'b1;
          q_nxt.cnt        = 12'h000;
          q_nxt.state = S_SUSPENDING;
        end else if (cmdSectorErase && (target & protAll) == 12'h000) begin
          q_nxt.eraseSec = q_r.eraseSec | target;
          q_nxt.cnt      = 12'h000;
        end else if (cmdSectorErase || isUnlock || isResume) begin
          q_nxt.state = S_TMO;
        end else if (cmdWr || cmdProgram || cmdBulkErase) begin
          q_nxt.abort    = 1'b1;
          q_nxt.eraseSec = 12'h000;
          q_nxt.cnt      = 12'h000;
          q_nxt.state    = S_RECOVER;
        end else if (q_r.cnt == ERASE_TMO_CYC - 12'd1) begin
          q_nxt.startErase = 1'b1;
          q_nxt.state      = S_ERASE;
        end else begin
          q_nxt.cnt = q_r.cnt + 12'd1;
        end
      end
      S_ERASE: begin
        if (isSuspend) begin
          q_nxt.cnt   = 12'h000;
          q_nxt.state = S_SUSPENDING;
        end else if (isReset) begin
          q_nxt.abort    = 1'b1;
          q_nxt.eraseSec = 12'h000;
          q_nxt.cnt      = 12'h000;
          q_nxt.state    = S_RECOVER;
        end else if (algoError) begin
          q_nxt.err      = 1'b1;
          q_nxt.eraseSec = 12'h000;
          q_nxt.state    = S_READ;
        end else if (algoDone) begin
          q_nxt.eraseSec = 12'h000;
          q_nxt.state    = S_READ;
        end
      end
      S_SUSPENDING, S_SUSPENDED: begin
        // program, erase and other writes are refused; reset-flash acts while settling too
        if (isResume) begin
          q_nxt.state = S_ERASE;
        end else if (isReset) begin
          q_nxt.invalid  = q_r.invalid | q_r.eraseSec;
          q_nxt.abort    = 1'b1;
          q_nxt.eraseSec = 12'h000;
          q_nxt.cnt      = 12'h000;
          q_nxt.state    = S_RECOVER;
        end else if (q_r.cnt == SUSP_CYC - 12'd1) begin
          // toggle runs until the engine has settled; the count then holds
          q_nxt.state = S_SUSPENDED;
        end else begin
          q_nxt.cnt = q_r.cnt + 12'd1;
        end
      end
      S_RECOVER: begin
        if (q_r.cnt == RECOVER_CYC - 12'd1) begin
          q_nxt.state = S_READ;
        end else begin
          q_nxt.cnt = q_r.cnt + 12'd1;
        end
      end
      default: begin
        q_nxt.state = S_READ;
      end
    endcase

    // a sector newly erased to completion holds good data again
    if ((q_r.state == S_ERASE || q_r.state == S_BULK) && algoDone && !algoError) begin
      q_nxt.invalid = q_r.invalid & ~q_r.eraseSec;
    end

    // space map writes; protection registers ignore writes
    if (busWr && ioRegisterSpace && busAddr[7:0] == SPACE_MAP_OFS) begin
      q_nxt.spaceMap = busWrData & MAP_WR_MASK;
    end

    // register reads in the io space
    if (busRd && ioRegisterSpace) begin
      q_nxt.rdValid = 1'b1;
      case (busAddr[7:0])
        PROT_PRI_OFS:  q_nxt.rdData = primaryProtect;
        PROT_SEC_OFS:  q_nxt.rdData = {securityLock, 3'b000, secondaryProtect};
        SPACE_MAP_OFS: q_nxt.rdData = q_r.spaceMap;
        default:       q_nxt.rdData = 8'h00;
      endcase
    end else if (flashRd && busyState && (target & q_r.eraseSec) != 12'h000) begin
      // status byte replaces array data while the sector is busy
      q_nxt.toggle                 = ~q_r.toggle;
      q_nxt.rdValid                = 1'b1;
      q_nxt.rdData[ST_TOGGLE]      = q_r.toggle;
      q_nxt.rdData[ST_ERROR]       = q_r.err;
      q_nxt.rdData[ST_TIMEOUT]     = (q_r.state != S_TMO);
    end else if (flashRd && q_r.state == S_PROG) begin
      q_nxt.toggle            = ~q_r.toggle;
      q_nxt.rdValid           = 1'b1;
      q_nxt.rdData[ST_TOGGLE] = q_r.toggle;
      q_nxt.rdData[ST_ERROR]  = q_r.err;
    end else if (flashRd && q_r.state == S_SUSPENDED) begin
      q_nxt.rdInvalid = (target & q_r.eraseSec) != 12'h000;
    end

    // access steering with priority and space-map gating
    q_nxt.sramGnt  = sramSelect & (~programFetchStrobe
                   | q_r.spaceMap[MAP_SRAM_CODE]);
    q_nxt.ioGnt    = ioRegisterSpace & ~sramSelect;
    q_nxt.pioGnt   = peripheralIoSelect & q_r.spaceMap[MAP_PERIPHERAL_IO_ENABLE]
                   & ~sramSelect & ~ioRegisterSpace;
    q_nxt.secGrant = (hiPri ? 4'h0 : secondarySectorSelects)
                   & {4{(busRd & q_r.spaceMap[MAP_SEC_DATA])
                   | (programFetchStrobe & q_r.spaceMap[MAP_SEC_CODE]) | busWr}};
    q_nxt.priGrant = ((hiPri || |secondarySectorSelects) ? 8'h00 : primarySectorSelects)
                   & {8{(busRd & q_r.spaceMap[MAP_PRI_DATA])
                   | (programFetchStrobe & q_r.spaceMap[MAP_PRI_CODE]) | busWr}};

    // status levels taken from the next state so each output leaves a flop
    q_nxt.hold    = (q_nxt.state == S_SUSPENDING) | (q_nxt.state == S_SUSPENDED);
    q_nxt.busy    = (q_nxt.state != S_READ) & (q_nxt.state != S_SUSPENDED);
    q_nxt.tmoFlag = (q_nxt.state != S_TMO);
  end

  // single state register; reset enters the recovery wait
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      q_r          <= '0;
      q_r.state    <= S_RECOVER;
      q_r.busy     <= 1'b1;
      q_r.tmoFlag  <= 1'b1;
      q_r.spaceMap <= SPACE_MAP_INIT & MAP_WR_MASK; // unused bits read 0
    end else begin
      q_r <= q_nxt;
    end
  end

  // outputs straight from the state register
  assign startProgram     = q_r.startProg;
  assign startSectorErase = q_r.startErase;
  assign startBulkErase   = q_r.startBulk;
  assign eraseSectors     = q_r.eraseSec;
  assign eraseHold        = q_r.hold;
  assign eraseAbort       = q_r.abort;
  assign sectorInvalid    = q_r.invalid;
  assign flashBusy        = q_r.busy;
  assign readData         = q_r.rdData;
  assign readDataValid    = q_r.rdValid;
  assign readDataInvalid  = q_r.rdInvalid;
  assign primaryGrant     = q_r.priGrant;
  assign secondaryGrant   = q_r.secGrant;
  assign sramGrant        = q_r.sramGnt;
  assign ioGrant          = q_r.ioGnt;
  assign peripheralGrant  = q_r.pioGnt;
  assign toggleFlag       = q_r.toggle;
  assign errorFlag        = q_r.err;
  assign eraseTimeoutFlag = q_r.tmoFlag;

endmodule // fes_flash_ctrl
`default_nettype wire

// ==== dv/fes_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module fes_monitor
  import fes_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [7:0]  busWrData,
  input wire logic        busWr,
  input wire logic        busRd,
  input wire logic        programFetchStrobe,
  input wire logic [7:0]  primarySectorSelects,
  input wire logic [3:0]  secondarySectorSelects,
  input wire logic        sramSelect,
  input wire logic        ioRegisterSpace,
  input wire logic        peripheralIoSelect,
  input wire logic        cmdProgram,
  input wire logic [7:0]  primaryProtect,
  input wire logic        startProgram,
  input wire logic        startBulkErase,
  input wire logic [11:0] eraseSectors,
  input wire logic        eraseHold,
  input wire logic        eraseAbort,
  input wire logic        flashBusy,
  input wire logic [7:0]  primaryGrant,
  input wire logic [3:0]  secondaryGrant,
  input wire logic        sramGrant,
  input wire logic        toggleFlag,
  input wire logic        errorFlag
);
  logic       anyStb, otherSel, rstCmd, bulk_r, rec_r;
  logic [9:0] recCnt_r;
  // flash command write: sector selected, nothing of higher priority in front
  assign anyStb   = busWr || busRd || programFetchStrobe;
  assign otherSel = sramSelect || ioRegisterSpace || peripheralIoSelect;
  assign rstCmd   = busWr && |{secondarySectorSelects, primarySectorSelects} && !otherSel
                    && busWrData == CMD_RESET_FLASH;
  // bulk run lasts until read mode; recovery is timed from reset, abort or error clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bulk_r   <= 1'b0;
      rec_r    <= 1'b1;
      recCnt_r <= 10'h000;
    end else begin
      bulk_r   <= startBulkErase || (bulk_r && flashBusy);
      rec_r    <= eraseAbort || (rstCmd && errorFlag) || (rec_r && flashBusy);
      recCnt_r <= (rec_r && !eraseAbort) ? recCnt_r + 10'h001 : 10'h000;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_hold_needs_erase: assert property ($rose(eraseHold) |-> $past(|eraseSectors))
    else $error("erase hold with no erase running");
  chk_held_no_start: assert property (
    eraseHold && $past(eraseHold) |-> !startProgram && !startBulkErase)
    else $error("operation started while erase held");
  chk_toggle_frozen: assert property (eraseHold && $past(eraseHold, 4) |-> $stable(toggleFlag))
    else $error("toggle flag moved while suspended");
  chk_reset_aborts: assert property (
    rstCmd && |eraseSectors && !eraseHold && !bulk_r && flashBusy |=> eraseAbort)
    else $error("reset-flash did not abort erase");
  chk_bulk_keeps: assert property (rstCmd && bulk_r |=> !eraseAbort && flashBusy)
    else $error("reset-flash disturbed bulk erase");
  chk_secondary_wins: assert property (
    anyStb && |secondarySectorSelects |=> primaryGrant == 8'h00)
    else $error("primary granted over secondary");
  chk_sram_io_first: assert property (
    anyStb && otherSel |=> primaryGrant == 8'h00 && secondaryGrant == 4'h0)
    else $error("flash granted over sram or io");
  chk_sram_needs_sel: assert property (sramGrant |-> $past(sramSelect))
    else $error("sram granted without select");
  chk_protect_blocks: assert property (
    cmdProgram && |(primarySectorSelects & primaryProtect) |=> !startProgram [*2])
    else $error("program started on protected sector");
  chk_recover_time: assert property (recCnt_r < 10'd640)
    else $error("read mode not reached in time");
  cov_abort:   cover property (eraseAbort);
  cov_suspend: cover property ($rose(eraseHold));
  cov_bulk:    cover property (startBulkErase);
endmodule // fes_monitor
bind fes_flash_ctrl fes_monitor mon (.*);
`default_nettype wire

// ==== dv/fes_cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module fes_cpu_model (
  input  wire logic        clk,
  input  wire logic [7:0]  readData,
  input  wire logic        readDataValid,
  input  wire logic        readDataInvalid,
  output logic [15:0]      busAddr,
  output logic [7:0]       busWrData,
  output logic             busWr,
  output logic             busRd,
  output logic             programFetchStrobe,
  output logic [7:0]       primarySectorSelects,
  output logic [3:0]       secondarySectorSelects,
  output logic             sramSelect,
  output logic             ioRegisterSpace,
  output logic             peripheralIoSelect
);
  logic [7:0] rdSeen;
  logic       rdOk, rdBad;
  // bus idles with strobes and selects low
  initial begin
    {busAddr, busWrData, busWr, busRd, programFetchStrobe} = 27'h0;
    {primarySectorSelects, secondarySectorSelects} = 12'h000;
    {sramSelect, ioRegisterSpace, peripheralIoSelect} = 3'b000;
  end
  // one cycle: k = {write, read, fetch}, sel = {secondary, primary}, o = {sram, io, pio}
  task automatic xfer(input logic [2:0] k, input logic [15:0] a, input logic [7:0] d,
                      input logic [11:0] sel, input logic [2:0] o);
    @(posedge clk);
    {busWr, busRd, programFetchStrobe} <= k;
    busAddr <= a;
    busWrData <= d;
    {secondarySectorSelects, primarySectorSelects} <= sel;
    {sramSelect, ioRegisterSpace, peripheralIoSelect} <= o;
    @(posedge clk);
    {busWr, busRd, programFetchStrobe} <= 3'b000;
    // released address and data lines flip so a stale value is never mistaken for a held one
    busAddr <= ~a;
    busWrData <= ~d;
    {secondarySectorSelects, primarySectorSelects} <= 12'h000;
    {sramSelect, ioRegisterSpace, peripheralIoSelect} <= 3'b000;
    #1;
    rdSeen = readData;
    rdOk = readDataValid;
    rdBad = readDataInvalid;
  endtask
endmodule // fes_cpu_model
`default_nettype wire

// ==== dv/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fes_pkg::*;
  logic        clk, reset_n, cmdProgram, cmdSectorErase, cmdBulkErase, algoDone, algoError;
  logic        busWr, busRd, programFetchStrobe, sramSelect, ioRegisterSpace, peripheralIoSelect;
  logic        securityLock, startProgram, startSectorErase, startBulkErase, eraseHold;
  logic        eraseAbort, flashBusy, readDataValid, readDataInvalid, sramGrant, ioGrant;
  logic        peripheralGrant, toggleFlag, errorFlag, eraseTimeoutFlag;
  logic [15:0] busAddr;
  logic [11:0] eraseSectors, sectorInvalid;
  logic [7:0]  busWrData, primarySectorSelects, primaryProtect, readData, primaryGrant, m, t;
  logic [3:0]  secondarySectorSelects, secondaryProtect, secondaryGrant;
  int          err_count, n_compared, cyc;
  fes_flash_ctrl #(.SPACE_MAP_INIT(8'hff)) dut (.*);
  fes_cpu_model cpu (.*);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic close_out;
    if (err_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // hang guard, well above the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      close_out();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic [2:0] k, input logic [11:0] sel, input logic [2:0] o);
    cpu.xfer(k, 16'h8000, 8'h00, sel, o);
  endtask
  task automatic cmd(input logic [7:0] d, input logic [11:0] a, input logic [11:0] sel);
    cpu.xfer(3'b100, {4'h0, a}, d, sel, 3'b000);
  endtask
  task automatic reg_io(input logic [2:0] k, input logic [7:0] ofs, input logic [7:0] d);
    cpu.xfer(k, {8'h00, ofs}, d, 12'h000, 3'b010);
  endtask
  // decoder pulse {bulk, sector, program} with the target sector selected that cycle
  task automatic op(input logic [2:0] k, input logic [11:0] sel);
    fork
      acc(3'b000, sel, 3'b000);
      begin
        @(posedge clk);
        {cmdBulkErase, cmdSectorErase, cmdProgram} <= k;
        @(posedge clk);
        {cmdBulkErase, cmdSectorErase, cmdProgram} <= 3'b000;
      end
    join
  endtask
  task automatic finish_algo(input logic err);
    @(posedge clk);
    {algoDone, algoError} <= {1'b1, err};
    @(posedge clk);
    {algoDone, algoError} <= 2'b00;
    #1;
  endtask
  task automatic wait_idle;
    for (int n = 0; n < 700 && flashBusy !== 1'b0; n++) begin
      @(posedge clk);
      #1;
    end
    check(flashBusy, 1'b0);
  endtask
  initial begin
    reset_n = 1'b0;
    {cmdProgram, cmdSectorErase, cmdBulkErase, algoDone, algoError} = 5'h00;
    {primaryProtect, secondaryProtect, securityLock} = 13'h14ab;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    wait_idle();
    // registers: map reset value, read-only protection, unmapped place
    reg_io(3'b010, SPACE_MAP_OFS, 8'h00);
    check(cpu.rdSeen, 8'h9f);
    reg_io(3'b100, PROT_PRI_OFS, 8'h00);
    reg_io(3'b010, PROT_PRI_OFS, 8'h00);
    check(cpu.rdSeen, 8'ha5);
    reg_io(3'b010, PROT_SEC_OFS, 8'h00);
    check(cpu.rdSeen, 8'h85);
    reg_io(3'b010, 8'h7e, 8'h00);
    check({cpu.rdOk, cpu.rdSeen}, 9'h100);
    cmd(CMD_RESET_FLASH, 12'h000, 12'h001);
    // each map bit opens one path
    for (int i = 0; i < 7; i++) begin
      m = (i < 5) ? 8'h10 >> i : ((i == 5) ? 8'h80 : 8'h00);
      reg_io(3'b100, SPACE_MAP_OFS, m);
      acc(3'b010, 12'h001, 3'b000);
      check(primaryGrant, m[4]);
      acc(3'b010, 12'h100, 3'b000);
      check(secondaryGrant, m[3]);
      acc(3'b001, 12'h001, 3'b000);
      check(primaryGrant, m[2]);
      acc(3'b001, 12'h100, 3'b000);
      check(secondaryGrant, m[1]);
      acc(3'b001, 12'h000, 3'b100);
      check(sramGrant, m[0]);
      acc(3'b010, 12'h000, 3'b001);
      check(peripheralGrant, m[7]);
    end
    // overlapping selects
    reg_io(3'b100, SPACE_MAP_OFS, 8'h1f);
    acc(3'b010, 12'h101, 3'b000);
    check({secondaryGrant, primaryGrant}, 12'h100);
    acc(3'b010, 12'h101, 3'b100);
    check({sramGrant, 3'b000, primaryGrant}, 12'h800);
    acc(3'b010, 12'h001, 3'b010);
    check({ioGrant, 3'b000, primaryGrant}, 12'h800);
    // protected sectors ignore program and erase
    op(3'b001, 12'h001);
    check(startProgram, 1'b0);
    op(3'b010, 12'h004);
    check(eraseSectors, 12'h000);
    // failed program, then reset-flash behind both unlock writes
    op(3'b001, 12'h002);
    check(startProgram, 1'b1);
    finish_algo(1'b1);
    check(errorFlag, 1'b1);
    cmd(UNLOCK1_DATA, UNLOCK1_ADDR, 12'h002);
    cmd(UNLOCK2_DATA, UNLOCK2_ADDR, 12'h002);
    cmd(CMD_RESET_FLASH, 12'h000, 12'h002);
    wait_idle();
    check(errorFlag, 1'b0);
    // erase, toggle polling, suspend, reads, refused program, resume
    op(3'b010, 12'h002);
    check({eraseTimeoutFlag, eraseSectors}, 16'h0002);
    acc(3'b010, 12'h002, 3'b000);
    t = cpu.rdSeen;
    acc(3'b010, 12'h002, 3'b000);
    check(cpu.rdSeen[6], !t[6]);
    for (int n = 0; n < 2600 && startSectorErase !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    check(startSectorErase, 1'b1);
    cmd(CMD_SUSPEND, 12'h000, 12'h002);
    check(eraseHold, 1'b1);
    repeat (4) @(posedge clk);
    acc(3'b010, 12'h002, 3'b000);
    check(cpu.rdBad, 1'b1);
    acc(3'b010, 12'h008, 3'b000);
    check({cpu.rdBad, cpu.rdOk}, 2'b00);
    op(3'b001, 12'h008);
    check(startProgram, 1'b0);
    cmd(CMD_RESUME, 12'h000, 12'h002);
    check(eraseHold, 1'b0);
    finish_algo(1'b0);
    wait_idle();
    // suspend inside the time-out window, then reset-flash while held
    op(3'b010, 12'h008);
    cmd(CMD_SUSPEND, 12'h000, 12'h008);
    check({eraseHold, eraseTimeoutFlag}, 2'b11);
    cmd(CMD_RESET_FLASH, 12'h000, 12'h008);
    wait_idle();
    check(sectorInvalid, 12'h008);
    // reset-flash aborts a secondary sector erase
    op(3'b010, 12'h200);
    cmd(CMD_RESET_FLASH, 12'h000, 12'h200);
    check(eraseAbort, 1'b1);
    wait_idle();
    // reset-flash during bulk erase is ignored
    op(3'b100, 12'h002);
    check(startBulkErase, 1'b1);
    cmd(CMD_RESET_FLASH, 12'h000, 12'h002);
    check({eraseAbort, flashBusy}, 2'b01);
    finish_algo(1'b0);
    wait_idle();
    // reset pulse inside the erase time-out window, held for the full recovery time
    op(3'b010, 12'h002);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (RECOVER_CYC) @(posedge clk);
    check(eraseSectors, 12'h000);
    reset_n <= 1'b1;
    wait_idle();
    close_out();
  end
endmodule // tb
`default_nettype wire
